/* File: hw/sfa_array_seq.sv */
// sfa_array_seq: serial command decoder and self-timed sequencer for the
// array commands (block erase, program through buffer, page to buffer
// transfer, compare, auto rewrite), with the main array and both buffers.
// assumes csN, sck, si come from a host master outside core_clk's domain;
// the peek ports are driven by logic on core_clk.
import sfa_pkg::*;

module sfa_array_seq #(
  parameter int PAGES = SFA_PAGES,
  parameter int PAGE_BYTES = SFA_PAGE_BYTES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  output logic [7:0] statusByte,
  input wire logic [SFA_ARR_AW-1:0] peekArrAddr,
  output logic [7:0] peekArrData,
  input wire logic [SFA_BUF_AW-1:0] peekBufAddr,
  output logic [7:0] peekBufData
);

  // two-flop synchronisers for the pins
  logic [2:0] pinMeta_q;
  logic [2:0] pinSync_q;
  logic csPrev_q;
  logic sckPrev_q;

  // serial frame state
  logic [31:0] shReg_q;
  logic [5:0] bitCnt_q;
  logic [2:0] dataBitCnt_q;
  logic [7:0] opcode_q;
  logic [23:0] addr_q;
  logic [8:0] bufPtr_q;
  logic frameWe_q;
  logic [SFA_BUF_AW-1:0] frameWaddr_q;
  logic [7:0] frameWdata_q;

  // sequencer state
  sfa_state_t state_q, state_d;
  sfa_cmd_t cmd_q;
  logic [8:0] idx_q;
  logic step_q;
  logic [2:0] pageCnt_q;
  logic mismatch_q;
  logic cmpResult_q;
  logic [7:0] status_q;

  // memory ports
  logic [7:0] arrRdata;
  logic [7:0] bufRdata;

  // map an opcode onto a command kind
  function automatic sfa_cmd_kind_t decodeKind(input logic [7:0] op);
    case (op)
      SFA_OP_BLOCK_ERASE: decodeKind = SFA_CMD_BLOCK_ERASE;
      SFA_OP_PROG_BUF1, SFA_OP_PROG_BUF2: decodeKind = SFA_CMD_PROG_THRU_BUF;
      SFA_OP_XFER_BUF1, SFA_OP_XFER_BUF2: decodeKind = SFA_CMD_PAGE_TO_BUF;
      SFA_OP_CMP_BUF1, SFA_OP_CMP_BUF2: decodeKind = SFA_CMD_COMPARE;
      SFA_OP_REWR_BUF1, SFA_OP_REWR_BUF2: decodeKind = SFA_CMD_REWRITE;
      default: decodeKind = SFA_CMD_NONE;
    endcase
  endfunction

  // buffer two is the higher opcode of every opcode pair
  function automatic logic decodeBuf(input logic [7:0] op);
    decodeBuf = (op == SFA_OP_PROG_BUF2) || (op == SFA_OP_XFER_BUF2) ||
                (op == SFA_OP_CMP_BUF2) || (op == SFA_OP_REWR_BUF2);
  endfunction

  // linear array address of a byte in a page
  function automatic logic [SFA_ARR_AW-1:0] arrayAddr(input logic [10:0] page,
                                                      input logic [8:0] b);
    logic [SFA_ARR_AW-1:0] p;
    p = SFA_ARR_AW'(page);
    arrayAddr = SFA_ARR_AW'(p * SFA_ARR_AW'(PAGE_BYTES)) + SFA_ARR_AW'(b);
  endfunction

  // synchronised pins and their edges
  wire logic csSync = pinSync_q[2];
  wire logic sckSync = pinSync_q[1];
  wire logic siSync = pinSync_q[0];
  wire logic csLow = !csSync;
  wire logic csFall = !csSync && csPrev_q;
  wire logic csRise = csSync && !csPrev_q;
  wire logic sckRise = sckSync && !sckPrev_q && csLow;
  wire logic [7:0] rxByte = {shReg_q[6:0], siSync};

  // frame decode
  wire logic headerDone = (bitCnt_q == SFA_HEADER_BITS);
  wire sfa_cmd_kind_t frameKind = decodeKind(opcode_q);
  wire logic busy = (state_q != SFA_ST_IDLE);
  wire logic launch = csRise && headerDone && (frameKind != SFA_CMD_NONE) && !busy;
  wire logic dataByteDone = sckRise && headerDone && (dataBitCnt_q == 3'h7);
  wire sfa_cmd_t frameCmd = '{kind: frameKind, bufSel: decodeBuf(opcode_q),
                              page: addr_q[SFA_PAGE_MSB:SFA_PAGE_LSB]};

  // sequencer decode
  wire logic lastByte = step_q && (idx_q == SFA_LAST_BYTE);
  wire logic isBlockErase = (cmd_q.kind == SFA_CMD_BLOCK_ERASE);
  wire logic [10:0] curPage = isBlockErase ? {cmd_q.page[10:3], pageCnt_q} : cmd_q.page;
  wire logic [SFA_ARR_AW-1:0] arrAddr = arrayAddr(curPage, idx_q);
  wire logic [SFA_BUF_AW-1:0] seqBufAddr = {cmd_q.bufSel, idx_q};
  wire logic arrWe = step_q && ((state_q == SFA_ST_ERASE) || (state_q == SFA_ST_PROG));
  wire logic [7:0] arrWdata = (state_q == SFA_ST_ERASE) ? SFA_ERASED_BYTE : bufRdata;
  wire logic seqBufWe = step_q && (state_q == SFA_ST_XFER);
  wire logic bufWe = busy ? seqBufWe : frameWe_q;
  wire logic [SFA_BUF_AW-1:0] bufWaddr = busy ? seqBufAddr : frameWaddr_q;
  wire logic [7:0] bufWdata = busy ? arrRdata : frameWdata_q;
  wire logic byteDiffers = step_q && (state_q == SFA_ST_COMPARE) && (arrRdata != bufRdata);
  wire logic cmpDone = lastByte && (state_q == SFA_ST_COMPARE);

  // pin synchronisers; the first rank feeds only the second
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinMeta_q <= 3'h7;
      pinSync_q <= 3'h7;
      csPrev_q <= 1'b1;
      sckPrev_q <= 1'b1;
    end else begin
      pinMeta_q <= {csN, sck, si};
      pinSync_q <= pinMeta_q;
      csPrev_q <= csSync;
      sckPrev_q <= sckSync;
    end
  end

  // shift in opcode and address msb first on rising serial clock
  always_ff @(posedge core_clk) begin
    if (rst || csFall) begin
      shReg_q <= 32'h0000_0000;
      bitCnt_q <= 6'h00;
      dataBitCnt_q <= 3'h0;
    end else if (sckRise) begin
      shReg_q <= {shReg_q[30:0], siSync};
      if (!headerDone) begin
        bitCnt_q <= bitCnt_q + 6'h01;
      end else begin
        dataBitCnt_q <= dataBitCnt_q + 3'h1;
      end
    end
  end

  // capture opcode after eight bits and address after 32
  always_ff @(posedge core_clk) begin
    if (rst) begin
      opcode_q <= 8'h00;
      addr_q <= 24'h00_0000;
    end else if (csFall) begin
      opcode_q <= 8'h00;
    end else if (sckRise && (bitCnt_q == SFA_OPCODE_BITS - 6'h01)) begin
      opcode_q <= rxByte;
    end else if (sckRise && (bitCnt_q == SFA_HEADER_BITS - 6'h01)) begin
      addr_q <= {shReg_q[22:0], siSync};
    end
  end

  // program-through-buffer data bytes into the buffer, wrapping at the end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bufPtr_q <= 9'h000;
      frameWe_q <= 1'b0;
      frameWaddr_q <= '0;
      frameWdata_q <= 8'h00;
    end else begin
      frameWe_q <= dataByteDone && (frameKind == SFA_CMD_PROG_THRU_BUF) && !busy;
      if (sckRise && (bitCnt_q == SFA_HEADER_BITS - 6'h01)) begin
        bufPtr_q <= {shReg_q[SFA_BYTE_MSB-1:SFA_BYTE_LSB], siSync};
      end else if (dataByteDone) begin
        frameWaddr_q <= {decodeBuf(opcode_q), bufPtr_q};
        frameWdata_q <= rxByte;
        bufPtr_q <= (bufPtr_q == SFA_LAST_BYTE) ? 9'h000 : bufPtr_q + 9'h001;
      end
    end
  end

  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      SFA_ST_IDLE: begin
        if (launch) begin
          case (frameKind)
            SFA_CMD_BLOCK_ERASE: state_d = SFA_ST_ERASE;
            SFA_CMD_PROG_THRU_BUF: state_d = SFA_ST_ERASE;
            SFA_CMD_PAGE_TO_BUF: state_d = SFA_ST_XFER;
            SFA_CMD_COMPARE: state_d = SFA_ST_COMPARE;
            SFA_CMD_REWRITE: state_d = SFA_ST_XFER;
            default: state_d = SFA_ST_IDLE;
          endcase
        end
      end
      SFA_ST_XFER: begin
        if (lastByte) begin
          state_d = (cmd_q.kind == SFA_CMD_REWRITE) ? SFA_ST_ERASE : SFA_ST_IDLE;
        end
      end
      SFA_ST_ERASE: begin
        if (lastByte && isBlockErase) begin
          state_d = (pageCnt_q == SFA_LAST_PAGE_IN_BLOCK) ? SFA_ST_IDLE : SFA_ST_ERASE;
        end else if (lastByte) begin
          state_d = SFA_ST_PROG;
        end
      end
      SFA_ST_PROG: begin
        if (lastByte) begin
          state_d = SFA_ST_IDLE;
        end
      end
      SFA_ST_COMPARE: begin
        if (lastByte) begin
          state_d = SFA_ST_IDLE;
        end
      end
      default: state_d = SFA_ST_IDLE;
    endcase
  end

  // sequencer registers: each byte takes a read step and a use step
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= SFA_ST_IDLE;
      cmd_q <= '{kind: SFA_CMD_NONE, bufSel: 1'b0, page: 11'h000};
      idx_q <= 9'h000;
      step_q <= 1'b0;
      pageCnt_q <= 3'h0;
    end else begin
      state_q <= state_d;
      if (launch) begin
        cmd_q <= frameCmd;
        idx_q <= 9'h000;
        step_q <= 1'b0;
        pageCnt_q <= 3'h0;
      end else if (busy) begin
        step_q <= !step_q;
        if (lastByte) begin
          idx_q <= 9'h000;
          pageCnt_q <= pageCnt_q + 3'h1;
        end else if (step_q) begin
          idx_q <= idx_q + 9'h001;
        end
      end
    end
  end

  // compare result and status byte
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mismatch_q <= 1'b0;
      cmpResult_q <= 1'b0;
      status_q <= SFA_STATUS_RESET;
    end else begin
      mismatch_q <= launch ? 1'b0 : (mismatch_q || byteDiffers);
      if (cmpDone) begin
        cmpResult_q <= mismatch_q || byteDiffers;
      end
      status_q <= {state_d == SFA_ST_IDLE, cmpDone ? (mismatch_q || byteDiffers)
                   : cmpResult_q, SFA_DENSITY_CODE, 2'b00};
    end
  end

  assign statusByte = status_q;

  // main array and the two buffers
  sfa_byte_ram #(.WIDTH(8), .DEPTH(PAGES * PAGE_BYTES), .AW(SFA_ARR_AW)) arrayRam (
    .clk(core_clk),
    .we(arrWe),
    .waddr(arrAddr),
    .wdata(arrWdata),
    .raddrA(arrAddr),
    .rdataA(arrRdata),
    .raddrB(peekArrAddr),
    .rdataB(peekArrData)
  );

  sfa_byte_ram #(.WIDTH(8), .DEPTH(1 << SFA_BUF_AW), .AW(SFA_BUF_AW)) bufferRam (
    .clk(core_clk),
    .we(bufWe),
    .waddr(bufWaddr),
    .wdata(bufWdata),
    .raddrA(seqBufAddr),
    .rdataA(bufRdata),
    .raddrB(peekBufAddr),
    .rdataB(peekBufData)
  );

  // checks on the design's own behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_cmpEnd;
    cmpDone;
  endsequence

  sequence s_opEnd;
    busy ##1 !busy;
  endsequence

  a_busy_on_launch: assert property (launch |=> !status_q[SFA_ST_READY] && busy)
    else $error("status not busy after launch");
  a_ready_after_op: assert property (s_opEnd |-> status_q[SFA_ST_READY])
    else $error("status not ready after operation end");
  a_cmp_hold: assert property (!cmpDone |=> $stable(status_q[SFA_ST_CMP]))
    else $error("compare bit changed without a compare");
  a_cmp_result: assert property (
    s_cmpEnd |=> status_q[SFA_ST_CMP] == $past(mismatch_q || byteDiffers))
    else $error("compare bit does not match compare outcome");
  a_erase_ones: assert property (arrWe && state_q == SFA_ST_ERASE |-> arrWdata == 8'hFF)
    else $error("erase wrote a byte other than all ones");
  a_block_pages: assert property (
    arrWe && isBlockErase |-> curPage[10:3] == cmd_q.page[10:3])
    else $error("block erase left its block");
  a_buf_wrap: assert property (dataByteDone && bufPtr_q == 9'h107 |=> bufPtr_q == 9'h000)
    else $error("buffer pointer did not wrap");
  a_launch_known: assert property (launch |-> csRise && frameKind != SFA_CMD_NONE)
    else $error("operation launched without a known command on cs rise");
  a_sample_rise: assert property ($changed(shReg_q) && !$past(csFall) |-> $past(sckRise))
    else $error("serial input shifted without a rising clock");
  a_rewrite_order: assert property (
    state_q == SFA_ST_XFER && lastByte && cmd_q.kind == SFA_CMD_REWRITE
    |=> state_q == SFA_ST_ERASE ##[1:600] state_q == SFA_ST_PROG)
    else $error("rewrite did not erase then program");

endmodule // sfa_array_seq

/* File: hw/sfa_byte_ram.sv */
// sfa_byte_ram: byte memory with one write port and two registered read ports.
// assumes a single clock; contents are not reset.
module sfa_byte_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddrA,
  output logic [WIDTH-1:0] rdataA,
  input wire logic [AW-1:0] raddrB,
  output logic [WIDTH-1:0] rdataB
);

  logic [WIDTH-1:0] mem [DEPTH];

  // write, and both reads come out of registers
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdataA <= mem[raddrA];
    rdataB <= mem[raddrB];
  end

endmodule // sfa_byte_ram

/* File: shared/sfa_pkg.sv */
// sfa_pkg: opcodes, frame layout, array geometry, status layout and types
// shared by the flash array sequencer and its testbench.
// assumes a host spi master drives csN, sck and si; one core clock domain.
package sfa_pkg;

  // array geometry
  localparam int SFA_PAGES = 2048;
  localparam int SFA_PAGE_BYTES = 264;
  localparam int SFA_PAGES_PER_BLOCK = 8;
  localparam int SFA_ARR_AW = 20;   // enough for pages * page bytes
  localparam int SFA_BUF_AW = 10;   // buffer select + 9-bit byte address
  localparam logic [8:0] SFA_LAST_BYTE = 9'h107;   // byte 263
  localparam logic [2:0] SFA_LAST_PAGE_IN_BLOCK = 3'h7;
  localparam logic [7:0] SFA_ERASED_BYTE = 8'hFF;

  // opcodes of the array commands handled here
  localparam logic [7:0] SFA_OP_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] SFA_OP_PROG_BUF1 = 8'h82;
  localparam logic [7:0] SFA_OP_PROG_BUF2 = 8'h85;
  localparam logic [7:0] SFA_OP_XFER_BUF1 = 8'h53;
  localparam logic [7:0] SFA_OP_XFER_BUF2 = 8'h55;
  localparam logic [7:0] SFA_OP_CMP_BUF1 = 8'h60;
  localparam logic [7:0] SFA_OP_CMP_BUF2 = 8'h61;
  localparam logic [7:0] SFA_OP_REWR_BUF1 = 8'h58;
  localparam logic [7:0] SFA_OP_REWR_BUF2 = 8'h59;

  // serial frame: 8 opcode bits then 24 address bits, msb first
  localparam logic [5:0] SFA_OPCODE_BITS = 6'h08;
  localparam logic [5:0] SFA_HEADER_BITS = 6'h20;
  localparam int SFA_PAGE_MSB = 19;   // page_addr_bits in the 24-bit field
  localparam int SFA_PAGE_LSB = 9;
  localparam int SFA_BLOCK_MSB = 19;  // block number is page bits 10..3
  localparam int SFA_BLOCK_LSB = 12;
  localparam int SFA_BYTE_MSB = 8;    // buffer_byte_addr_bits
  localparam int SFA_BYTE_LSB = 0;

  // status byte layout
  localparam int SFA_ST_READY = 7;
  localparam int SFA_ST_CMP = 6;
  localparam logic [3:0] SFA_DENSITY_CODE = 4'h7;   // bits 5..2 read 0111
  localparam logic [7:0] SFA_STATUS_RESET = 8'h9C;  // ready, match, density

  typedef enum logic [2:0] {
    SFA_CMD_NONE = 3'b000,
    SFA_CMD_BLOCK_ERASE = 3'b001,
    SFA_CMD_PROG_THRU_BUF = 3'b010,
    SFA_CMD_PAGE_TO_BUF = 3'b011,
    SFA_CMD_COMPARE = 3'b100,
    SFA_CMD_REWRITE = 3'b101
  } sfa_cmd_kind_t;

  typedef enum logic [2:0] {
    SFA_ST_IDLE = 3'b000,
    SFA_ST_XFER = 3'b001,
    SFA_ST_ERASE = 3'b010,
    SFA_ST_PROG = 3'b011,
    SFA_ST_COMPARE = 3'b100
  } sfa_state_t;

  // a decoded command, latched when chip select rises
  typedef struct packed {
    sfa_cmd_kind_t kind;
    logic bufSel;
    logic [10:0] page;
  } sfa_cmd_t;

endpackage

/* File: tb/sfa_array_seq_test.sv */
// sfa_array_seq_test: self-checking bench for the array command sequencer.
// assumes sfa_host_model drives the serial pins; results are read through peeks.
module sfa_array_seq_test import sfa_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  `define SFA_CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin failures++; \
    $display("ERROR %s expected %h seen %h", nm, ex, gt); end end

  typedef struct {logic [1:0] kind; logic [7:0] expv;} sfa_note_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic csN;
  logic sck;
  logic si;
  logic [7:0] statusByte;
  logic [7:0] peekArrData;
  logic [7:0] peekBufData;
  logic [19:0] peekArrAddr = '0;
  logic [9:0] peekBufAddr = '0;
  logic rdStrobe = 1'b0;
  logic rdSeen = 1'b0;
  logic cmpNow = 1'b0;
  logic [31:0] d;
  logic [15:0] e;
  logic [7:0] got;
  integer seed = 53;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  sfa_note_t notes[$];
  sfa_note_t n;

  always #20 core_clk = ~core_clk;

  sfa_array_seq sfa_array_seq_i (.core_clk(core_clk), .rst(rst), .csN(csN), .sck(sck), .si(si),
    .statusByte(statusByte), .peekArrAddr(peekArrAddr), .peekArrData(peekArrData),
    .peekBufAddr(peekBufAddr), .peekBufData(peekBufData));
  sfa_host_model sfa_host_model_i (.core_clk(core_clk), .csN(csN), .sck(sck), .si(si));

  // print counts and verdict, then stop
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // cut a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("ERROR timeout expected done seen hang");
      close_out();
    end
  end

  // monitor: a peek result lands one cycle after its address, then matches the oldest note
  always @(posedge core_clk) rdSeen <= rdStrobe;
  always @(negedge core_clk) begin
    if (rdSeen === 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      got = (n.kind == 2'd0) ? peekArrData : (n.kind == 2'd1) ? peekBufData : statusByte;
      `SFA_CHK(n.kind == 2'd0 ? "array" : n.kind == 2'd1 ? "buffer" : "status", n.expv, got)
    end
  end

  function automatic logic [19:0] arr(input int pg, input int by);
    return 20'(pg * SFA_PAGE_BYTES + by);
  endfunction

  // kind 0 array, 1 buffer, 2 status; note the expected byte and raise a read
  task automatic peek(input logic [1:0] k, input logic [19:0] a, input logic [7:0] ex);
    @(negedge core_clk);
    if (k == 2'd0) peekArrAddr = a;
    else peekBufAddr = a[9:0];
    notes.push_back('{k, ex});
    rdStrobe = 1'b1;
    @(negedge core_clk);
    rdStrobe = 1'b0;
  endtask

  // one array command: frame it, see busy, wait bounded for ready
  task automatic run(input logic [63:0] w, input int nb);
    int k;
    k = 0;
    sfa_host_model_i.frame(w, nb);
    repeat (8) @(negedge core_clk);
    peek(2'd2, 20'h0, {1'b0, cmpNow, 6'h1C});
    while (statusByte[7] !== 1'b1 && k < 6000) begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 6000) begin
      failures++;
      $display("ERROR ready expected 1 seen %h", statusByte[7]);
    end
    repeat (2) @(negedge core_clk);
  endtask

  initial begin
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    peek(2'd2, 20'h0, 8'h9C);
    // block 5 chosen through page 45, whose low three bits are ignored
    run({SFA_OP_BLOCK_ERASE, 4'h0, 11'd45, 9'($random(seed)), 32'h0}, 32);
    peek(2'd0, arr(40, 0), 8'hFF);
    peek(2'd0, arr(47, 263), 8'hFF);
    $display("test block erase done");
    run({SFA_OP_XFER_BUF2, 4'h0, 11'd47, 9'($random(seed)), 32'h0}, 32);
    peek(2'd1, 20'h200, 8'hFF);
    peek(2'd1, 20'h307, 8'hFF);
    $display("test transfer done");
    // four bytes from byte 262 wrap to bytes 0 and 1
    d = $random(seed);
    run({SFA_OP_PROG_BUF2, 4'h0, 11'd41, 9'd262, d}, 64);
    peek(2'd0, arr(41, 262), d[31:24]);
    peek(2'd0, arr(41, 263), d[23:16]);
    peek(2'd0, arr(41, 0), d[15:8]);
    peek(2'd0, arr(41, 1), d[7:0]);
    peek(2'd0, arr(41, 100), 8'hFF);
    peek(2'd1, 20'h200, d[15:8]);
    $display("test program through buffer done");
    run({SFA_OP_CMP_BUF2, 4'h0, 11'd41, 9'h0, 32'h0}, 32);
    peek(2'd2, 20'h0, 8'h9C);
    run({SFA_OP_CMP_BUF2, 4'h0, 11'd40, 9'h0, 32'h0}, 32);
    cmpNow = 1'b1;
    peek(2'd2, 20'h0, 8'hDC);
    run({SFA_OP_XFER_BUF1, 4'h0, 11'd41, 9'h0, 32'h0}, 32);
    peek(2'd2, 20'h0, 8'hDC);
    peek(2'd1, 20'h001, d[7:0]);
    run({SFA_OP_CMP_BUF1, 4'h0, 11'd41, 9'h0, 32'h0}, 32);
    cmpNow = 1'b0;
    peek(2'd2, 20'h0, 8'h9C);
    $display("test compare done");
    e = 16'($random(seed));
    run({SFA_OP_PROG_BUF1, 4'h0, 11'd42, 9'h0, e, 16'h0}, 48);
    peek(2'd0, arr(42, 0), e[15:8]);
    peek(2'd0, arr(42, 262), d[31:24]);
    run({SFA_OP_REWR_BUF1, 4'h0, 11'd41, 9'h0, 32'h0}, 32);
    peek(2'd1, 20'h000, d[15:8]);
    peek(2'd0, arr(41, 0), d[15:8]);
    run({SFA_OP_REWR_BUF2, 4'h0, 11'd42, 9'h0, 32'h0}, 32);
    peek(2'd1, 20'h200, e[15:8]);
    peek(2'd0, arr(42, 1), e[7:0]);
    $display("test auto rewrite done");
    // unknown opcode and a short frame start nothing
    sfa_host_model_i.frame({8'hA5, 24'h0, 32'h0}, 32);
    repeat (12) @(negedge core_clk);
    peek(2'd2, 20'h0, 8'h9C);
    sfa_host_model_i.frame({SFA_OP_XFER_BUF1, 4'h0, 11'd47, 9'h0, 32'h0}, 16);
    repeat (12) @(negedge core_clk);
    peek(2'd2, 20'h0, 8'h9C);
    peek(2'd1, 20'h000, d[15:8]);
    // an erase framed while a transfer runs is refused
    sfa_host_model_i.frame({SFA_OP_XFER_BUF1, 4'h0, 11'd40, 9'h0, 32'h0}, 32);
    run({SFA_OP_BLOCK_ERASE, 4'h0, 11'd41, 9'h0, 32'h0}, 32);
    peek(2'd0, arr(41, 0), d[15:8]);
    peek(2'd1, 20'h000, 8'hFF);
    $display("test refusals done");
    repeat (4) @(negedge core_clk);
    close_out();
  end
endmodule // sfa_array_seq_test

/* File: tb/sfa_host_model.sv */
// sfa_host_model: host spi master that frames commands on csN, sck and si.
// assumes the bench calls frame() from its main process; sck idles low.
module sfa_host_model (
  input wire logic core_clk,
  output logic csN,
  output logic sck,
  output logic si
);
  timeunit 1ns;
  timeprecision 1ns;

  logic inFrame = 1'b0;

  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // outside a frame si carries no data, so it toggles every cycle
  always @(posedge core_clk) begin
    if (!inFrame) si <= ~si;
  end

  // send the first nb bits of w, msb first, at one sck period per 8 core cycles
  task automatic frame(input logic [63:0] w, input int nb);
    inFrame = 1'b1;
    @(negedge core_clk);
    csN = 1'b0;
    for (int i = 63; i > 63 - nb; i--) begin
      si = w[i];
      repeat (4) @(negedge core_clk);
      sck = 1'b1;
      repeat (4) @(negedge core_clk);
      sck = 1'b0;
    end
    repeat (4) @(negedge core_clk);
    csN = 1'b1;
    @(negedge core_clk);
    inFrame = 1'b0;
  endtask
endmodule // sfa_host_model
